// ===== src/rrs_pkg.sv
// Overview of operation
// - bits 26:20 give the first data-bit collision position
// - collision position means something only while the collision flag is one
// - position equals physical bit position plus the receive bit-alignment offset
// - only collisions inside the first 8 received bytes are captured
// - position is zero based: 0x00 first bit up to 0x7f 128th bit
// - parity or stop bit collisions leave the position unchanged
// - bits 19:17 give valid bits of last byte, 0 meaning all eight
// - bits 16:13 count normally completed frames in multi-frame mode
// - frame count valid only while multi-frame enable is one
// - bits 12:0 hold the received byte count
// - byte count not meaningful while multi-frame reception is enabled
// - collision flag in error register bit 18 set on any collision
package rrs_pkg;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned IDX_W    = ADDR_W - 2;
   // printed offsets are word indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h05;
   localparam logic [IDX_W-1:0] IDX_ERROR    = 6'h06;
   localparam logic [IDX_W-1:0] IDX_CTRL     = 6'h07;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h08;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h09;

   localparam int unsigned POS_W    = 7;
   localparam int unsigned LAST_W   = 3;
   localparam int unsigned FRM_W    = 4;
   localparam int unsigned BYTES_W  = 13;
   localparam int unsigned RSVD_LSB = 27;
   localparam int unsigned RSVD_W   = 5;
   localparam int unsigned COLL_FLAG_BIT = 18;
   localparam int unsigned ALIGN_W  = 3;
   localparam int unsigned CTRL_MULTI_BIT = 0;
   localparam int unsigned CTRL_ALIGN_LSB = 1;
   localparam int unsigned IRQ_W    = 2;
   localparam int unsigned IRQ_FRAME_BIT = 0;
   localparam int unsigned IRQ_COLL_BIT  = 1;
   localparam int unsigned BITCNT_W = 16;
   localparam logic [BITCNT_W-1:0] COLL_WINDOW_BITS = 16'h0040;

   typedef enum logic [0:0] {
      RRS_IDLE  = 1'b0,
      RRS_FRAME = 1'b1
   } rrs_state_t;

   // events from the receive decoder, one-cycle pulses on pclk
   typedef struct packed {
      logic frame_start;
      logic frame_end;
      logic frame_ok;
      logic data_bit;
      logic parity_bit;
      logic stop_bit;
      logic collision;
      logic byte_done;
   } rrs_rx_evt_t;

   typedef struct packed {
      logic [POS_W-1:0]   pos;
      logic               pos_upd;
      logic               coll_any;
      logic [LAST_W-1:0]  last_bits;
      logic [BYTES_W-1:0] bytes;
      logic               frame_ok;
   } rrs_frame_res_t;
endpackage

// ===== src/rrs_frame_acc.sv
module rrs_frame_acc
   import rrs_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               pce,
   input  wire rrs_rx_evt_t        evt,
   input  wire logic [ALIGN_W-1:0] bit_align,
   output rrs_frame_res_t          res,
   output logic                    commit
);
   rrs_state_t          state_r;
   logic [BITCNT_W-1:0] bit_cnt_r;
   logic [BYTES_W-1:0]  bytes_r;
   logic                found_r;
   logic                any_r;
   logic [POS_W-1:0]    pos_r;

   wire in_frame   = (state_r == RRS_FRAME);
   wire busy       = in_frame & ~evt.frame_end & ~evt.frame_start;
   wire data_coll  = busy & evt.data_bit & evt.collision;
   wire in_window  = (bit_cnt_r < COLL_WINDOW_BITS);
   wire first_coll = data_coll & ~found_r & in_window;
   wire [POS_W-1:0] pos_calc = POS_W'(bit_cnt_r + BITCNT_W'(bit_align));

   assign commit        = pce & in_frame & evt.frame_end;
   assign res.pos       = pos_r;
   assign res.pos_upd   = found_r;
   assign res.coll_any  = any_r;
   assign res.last_bits = bit_cnt_r[LAST_W-1:0];
   assign res.bytes     = bytes_r;
   assign res.frame_ok  = evt.frame_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r   <= RRS_IDLE;
         bit_cnt_r <= '0;
         bytes_r   <= '0;
         found_r   <= 1'b0;
         any_r     <= 1'b0;
         pos_r     <= '0;
      end else if (pce) begin
         if (evt.frame_start) begin
            state_r   <= RRS_FRAME;
            bit_cnt_r <= '0;
            bytes_r   <= '0;
            found_r   <= 1'b0;
            any_r     <= 1'b0;
         end else begin
            case (state_r)
               RRS_IDLE: begin
                  state_r <= RRS_IDLE;
               end
               RRS_FRAME: begin
                  if (evt.frame_end) begin
                     state_r <= RRS_IDLE;
                  end
                  if (busy && evt.data_bit) begin
                     bit_cnt_r <= bit_cnt_r + 1'b1;
                  end
                  if (busy && evt.byte_done) begin
                     bytes_r <= bytes_r + 1'b1;
                  end
                  if (busy && evt.collision) begin
                     any_r <= 1'b1;
                  end
                  if (first_coll) begin
                     found_r <= 1'b1;
                     pos_r   <= pos_calc;
                  end
               end
               default: begin
                  state_r <= RRS_IDLE;
               end
            endcase
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_coll_window: assert property ($rose(found_r) |-> $past(bit_cnt_r) < COLL_WINDOW_BITS)
      else $error("collision captured beyond the first eight bytes");
   chk_pos_offset: assert property ($rose(found_r) |-> pos_r == POS_W'($past(bit_cnt_r) + $past(bit_align)))
      else $error("collision position lacks alignment offset");
   chk_pos_nondata: assert property (busy && pce && !evt.data_bit |=> $stable(found_r) && $stable(pos_r))
      else $error("non-data collision moved the position");
endmodule

// ===== src/rrs_irq.sv
module rrs_irq
   import rrs_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             pce,
   input  wire logic [IRQ_W-1:0] ev_set,
   input  wire logic [IRQ_W-1:0] ev_clr,
   input  wire logic [IRQ_W-1:0] mask,
   output logic [IRQ_W-1:0]      stat,
   output logic                  irq
);
   genvar i;
   generate
      for (i = 0; i < IRQ_W; i++) begin : g_bit
         // set beats a clear landing in the same cycle
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat[i] <= 1'b0;
            end else if (pce) begin
               stat[i] <= ev_set[i] | (stat[i] & ~ev_clr[i]);
            end
         end
      end
   endgenerate

   assign irq = |(stat & mask);
endmodule

// ===== src/rrs_top.sv
module rrs_top
   import rrs_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              pce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire rrs_rx_evt_t       rx_evt,
   output logic                   irq
);
   // committed status fields
   logic [POS_W-1:0]   coll_pos_r;
   logic [LAST_W-1:0]  last_bits_r;
   logic [FRM_W-1:0]   frames_r;
   logic [BYTES_W-1:0] bytes_r;
   logic               coll_flag_r;
   // software controls
   logic               multi_en_r;
   logic [ALIGN_W-1:0] bit_align_r;
   logic [IRQ_W-1:0]   irq_mask_r;
   logic [31:0]        prdata_r;

   rrs_frame_res_t     res;
   logic               commit;
   logic [IRQ_W-1:0]   irq_stat;

   rrs_frame_acc u_acc (
      .pclk      (pclk),
      .presetn   (presetn),
      .pce       (pce),
      .evt       (rx_evt),
      .bit_align (bit_align_r),
      .res       (res),
      .commit    (commit)
   );

   // ---------------- bus decode
   wire [IDX_W-1:0] idx     = paddr[ADDR_W-1:2];
   wire             aligned = (paddr[1:0] == 2'h0);
   wire sel_status   = aligned & (idx == IDX_STATUS);
   wire sel_error    = aligned & (idx == IDX_ERROR);
   wire sel_ctrl     = aligned & (idx == IDX_CTRL);
   wire sel_irq_stat = aligned & (idx == IDX_IRQ_STAT);
   wire sel_irq_mask = aligned & (idx == IDX_IRQ_MASK);
   wire mapped = sel_status | sel_error | sel_ctrl | sel_irq_stat | sel_irq_mask;

   wire setup_ph  = psel & ~penable;
   wire access_ph = psel & penable & pce;
   wire wr_ok     = access_ph & pwrite & mapped;
   wire rd_ok     = access_ph & ~pwrite & mapped;

   // the whole word is one register read, so fields stay coherent
   wire [31:0] status_word = {{RSVD_W{1'b0}}, coll_pos_r, last_bits_r, frames_r, bytes_r};
   wire [31:0] error_word  = 32'(coll_flag_r) << COLL_FLAG_BIT;
   wire [31:0] ctrl_word   = 32'({bit_align_r, multi_en_r});
   wire [31:0] irq_st_word = 32'(irq_stat);
   wire [31:0] irq_mk_word = 32'(irq_mask_r);

   wire [31:0] rd_mux = sel_status   ? status_word :
                        sel_error    ? error_word  :
                        sel_ctrl     ? ctrl_word   :
                        sel_irq_stat ? irq_st_word :
                        sel_irq_mask ? irq_mk_word : 32'h0000_0000;

   wire wr_ctrl = wr_ok & sel_ctrl & pstrb[0];
   wire wr_mask = wr_ok & sel_irq_mask & pstrb[0];
   // only the bits already shown to software get cleared, so a late event survives
   wire [IRQ_W-1:0] irq_clr = (rd_ok & sel_irq_stat) ? prdata_r[IRQ_W-1:0] : '0;

   // one access cycle, stretched while the clock enable is low
   assign pready  = pce;
   assign pslverr = access_ph & ~mapped;
   assign prdata  = prdata_r;

   // read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (pce && setup_ph && !pwrite) begin
         prdata_r <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         multi_en_r  <= 1'b0;
         bit_align_r <= '0;
         irq_mask_r  <= '0;
      end else if (pce) begin
         if (wr_ctrl) begin
            multi_en_r  <= pwdata[CTRL_MULTI_BIT];
            bit_align_r <= pwdata[CTRL_ALIGN_LSB +: ALIGN_W];
         end
         if (wr_mask) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
         end
      end
   end

   // ---------------- status commit at frame end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coll_pos_r  <= '0;
         last_bits_r <= '0;
         bytes_r     <= '0;
         coll_flag_r <= 1'b0;
      end else if (commit) begin
         if (res.pos_upd) begin
            coll_pos_r <= res.pos;
         end
         last_bits_r <= res.last_bits;
         bytes_r     <= res.bytes;
         coll_flag_r <= res.coll_any;
      end
   end

   // frame count is held at zero outside multi-frame mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frames_r <= '0;
      end else if (pce) begin
         if (!multi_en_r) begin
            frames_r <= '0;
         end else if (commit && res.frame_ok) begin
            frames_r <= frames_r + 1'b1;
         end
      end
   end

   // ---------------- interrupts
   wire [IRQ_W-1:0] irq_set = IRQ_W'({commit & res.coll_any, 1'b0}) |
                              IRQ_W'(commit);

   rrs_irq u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .pce     (pce),
      .ev_set  (irq_set),
      .ev_clr  (irq_clr),
      .mask    (irq_mask_r),
      .stat    (irq_stat),
      .irq     (irq)
   );

   // ---------------- checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_rsvd_zero: assert property (status_word[RSVD_LSB +: RSVD_W] == '0)
      else $error("reserved status bits not zero");
   chk_pos_commit: assert property (commit && res.pos_upd |=> coll_pos_r == $past(res.pos))
      else $error("collision position not committed");
   chk_pos_keep: assert property (commit && !res.pos_upd |=> $stable(coll_pos_r))
      else $error("position moved without a data-bit collision");
   chk_fields_together: assert property (commit |=> bytes_r == $past(res.bytes)
                                         && last_bits_r == $past(res.last_bits)
                                         && coll_flag_r == $past(res.coll_any))
      else $error("status fields not updated together");
   chk_hold_between: assert property (!commit |=> $stable(bytes_r) && $stable(last_bits_r)
                                      && $stable(coll_flag_r))
      else $error("status changed outside frame end");
   chk_frames_off: assert property (pce && !multi_en_r |=> frames_r == '0)
      else $error("frame count nonzero outside multi-frame mode");
   chk_frames_inc: assert property (commit && res.frame_ok && multi_en_r
                                    |=> frames_r == FRM_W'($past(frames_r) + 1'b1))
      else $error("frame count did not advance");
   chk_write_ignored: assert property (wr_ok && sel_status && !commit
                                       && (multi_en_r || frames_r == '0) |=> $stable(status_word))
      else $error("status word changed by a write");
   chk_read_clear: assert property (irq_clr != '0 && irq_set == '0 |=> (irq_stat & $past(irq_clr)) == '0)
      else $error("interrupt status not cleared by read");
   chk_irq_level: assert property (commit && irq_mask_r[IRQ_FRAME_BIT] |=> irq)
      else $error("masked-in frame event did not raise interrupt");
   // a low enable must hold every piece of state, bus side and receive side alike
   chk_freeze_state: assert property (!pce |=> $stable(frames_r) && $stable(irq_stat)
                                      && $stable(bit_align_r) && $stable(multi_en_r) && $stable(prdata))
      else $error("state moved while the clock enable was low");
   chk_set_wins: assert property (commit |=> irq_stat[IRQ_FRAME_BIT])
      else $error("frame event lost against a read clear");
   chk_coll_irq: assert property (commit && res.coll_any |=> irq_stat[IRQ_COLL_BIT])
      else $error("collision event did not set its status bit");
   chk_ctrl_write: assert property (wr_ctrl |=> multi_en_r == $past(pwdata[CTRL_MULTI_BIT])
                                    && bit_align_r == $past(pwdata[CTRL_ALIGN_LSB +: ALIGN_W]))
      else $error("control write did not land");
   chk_prdata_hold: assert property (!(pce && setup_ph && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read setup cycle");
   chk_unmapped_zero: assert property (pce && setup_ph && !pwrite && !mapped |=> prdata == '0)
      else $error("unmapped read returned nonzero data");

   cov_coll_frame: cover property (commit && res.pos_upd && res.coll_any);
   cov_multi_frames: cover property (commit && multi_en_r && frames_r == FRM_W'(2));
   cov_read_clear: cover property (irq_clr[IRQ_COLL_BIT] && irq);
   cov_bad_addr: cover property (pslverr);
   cov_stalled_access: cover property (psel && penable && !pce);
endmodule

// ===== testbench/test_rf_receive_status.sv
module test_rf_receive_status
   import rrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        pce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   rrs_rx_evt_t rx_evt = '0;
   logic        irq;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   logic [31:0] d;
   logic        err;

   rrs_top i_rrs_top (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt), .irq(irq));

   always #25 pclk = ~pclk;

   task automatic final_report();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // timeout well above the few hundred cycles the sequence needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // entered right after a rising edge; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      d       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so the next call never drives a strobe twice in one step
      @(posedge pclk);
   endtask

   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, d);
      chk("slverr on mapped read", 32'h0, {31'h0, err});
   endtask

   function automatic logic [31:0] st(input logic [6:0] p, input logic [2:0] l, input logic [3:0] f,
                                      input logic [12:0] b);
      return {5'h00, p, l, f, b};
   endfunction

   task automatic pulse(input rrs_rx_evt_t e);
      rx_evt <= e;
      @(posedge pclk);
   endtask

   // data bits, optional data-bit collision, parity collision, byte pulses, then end
   task automatic frame(input int nb, input int ci, input bit pc, input bit ok, input int nby);
      rrs_rx_evt_t e;
      e = '0;
      e.frame_start = 1'b1;
      pulse(e);
      for (int i = 0; i < nb; i++) begin
         e = '0;
         e.data_bit = 1'b1;
         e.collision = (i == ci);
         pulse(e);
      end
      e = '0;
      e.parity_bit = pc;
      e.collision = pc;
      if (pc) pulse(e);
      e = '0;
      e.byte_done = 1'b1;
      for (int i = 0; i < nby; i++) pulse(e);
      e = '0;
      pulse(e);
      e.frame_end = 1'b1;
      e.frame_ok = ok;
      pulse(e);
      pulse('0);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 5; i <= 9; i++) rd("reset value", 8'(i * 4), 32'h0);
      apb(1'b1, 8'h14, 32'hffffffff);
      rd("status after write", 8'h14, 32'h0);
      apb(1'b0, 8'h28, 32'h0);
      chk("unmapped slverr", 32'h1, {31'h0, err});
      apb(1'b0, 8'h15, 32'h0);
      chk("misaligned slverr", 32'h1, {31'h0, err});
      $display("test registers done");

      apb(1'b1, 8'h1c, 32'h00000006);
      frame(2, 0, 1'b0, 1'b1, 0);
      rd("first collision", 8'h14, st(7'h03, 3'h2, 4'h0, 13'h0));
      rd("collision flag", 8'h18, 32'h00040000);
      rd("irq status", 8'h20, 32'h3);
      rd("irq status cleared", 8'h20, 32'h0);
      $display("test collision done");

      apb(1'b1, 8'h24, 32'h1);
      frame(8, -1, 1'b0, 1'b1, 1);
      chk("irq raised", 32'h1, {31'h0, irq});
      rd("clean frame", 8'h14, st(7'h03, 3'h0, 4'h0, 13'h1));
      rd("no collision flag", 8'h18, 32'h0);
      rd("irq frame only", 8'h20, 32'h1);
      @(posedge pclk);
      chk("irq dropped", 32'h0, {31'h0, irq});
      frame(3, -1, 1'b1, 1'b1, 0);
      rd("parity collision", 8'h14, st(7'h03, 3'h3, 4'h0, 13'h0));
      rd("parity flag", 8'h18, 32'h00040000);
      rd("irq both", 8'h20, 32'h3);
      $display("test irq done");

      apb(1'b1, 8'h1c, 32'h0000000e);
      frame(65, 64, 1'b0, 1'b1, 8);
      rd("collision past window", 8'h14, st(7'h03, 3'h1, 4'h0, 13'h8));
      rd("late flag", 8'h18, 32'h00040000);
      frame(64, 63, 1'b0, 1'b1, 8);
      rd("last window bit", 8'h14, st(7'h46, 3'h0, 4'h0, 13'h8));
      $display("test window done");

      apb(1'b1, 8'h1c, 32'h1);
      frame(1, -1, 1'b0, 1'b1, 0);
      frame(1, -1, 1'b0, 1'b1, 0);
      frame(1, -1, 1'b0, 1'b0, 0);
      apb(1'b0, 8'h14, 32'h0);
      chk("frame count", st(7'h46, 3'h1, 4'h2, 13'h0), d & 32'hffffe000);
      apb(1'b1, 8'h1c, 32'h0);
      frame(1, -1, 1'b0, 1'b1, 0);
      rd("single mode count", 8'h14, st(7'h46, 3'h1, 4'h0, 13'h0));
      $display("test multi frame done");

      rd("irq before freeze", 8'h20, 32'h3);
      pce <= 1'b0;
      frame(2, 0, 1'b0, 1'b1, 3);
      pce <= 1'b1;
      rd("frozen status", 8'h14, st(7'h46, 3'h1, 4'h0, 13'h0));
      rd("frozen irq status", 8'h20, 32'h0);
      fork
         rd("stalled read", 8'h14, st(7'h46, 3'h1, 4'h0, 13'h0));
         begin
            @(posedge pclk);
            pce <= 1'b0;
            @(posedge pclk);
            chk("stalled pready", 32'h0, {31'h0, pready});
            repeat (2) @(posedge pclk);
            pce <= 1'b1;
         end
      join
      $display("test clock enable done");
      final_report();
   end
endmodule
